// [bench/led_driver_i2c_register_port_tb.sv]
// Self-checking testbench for the LED driver bus register port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module led_driver_i2c_register_port_tb;
	import ledi_pkg::*;
	localparam logic [7:0] ID_A = 8'h5c; // Arbitrary value.
	localparam logic [7:0] ID_B = 8'h3a; // Arbitrary value.
	localparam logic [7:0] ID_C = 8'h69; // Arbitrary value.
	localparam logic [7:0] DEF_VAL [0:12] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff,
		8'h00, ID_A, ID_B, ID_C};
	logic clock, sw_clock, rstn, scl, sda_pull, sda_out, sda_oe, supply_ok, ack;
	logic latchoff_enable, clock_out_enable, bus_mode;
	logic [1:0] pin_hi, pin_lo, dim_type_bam, dim_on;
	logic [7:0] fault_raw, ch1_analog_level, ch2_analog_level, rd;
	wire logic sda;
	int checked = 0;
	int fails = 0;

	// Open-drain data line with a pull-up.
	assign sda = ~(sda_pull | (sda_oe & ~sda_out));

	ledi_master master (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));

	ledi_port #(.ID_VALUE0(ID_A), .ID_VALUE1(ID_B), .ID_VALUE2(ID_C)) uut (.clock(clock), .rstn(rstn),
		.sw_clock(sw_clock), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_select_high_pin(pin_hi), .addr_select_low_pin(pin_lo), .internal_supply_ok(supply_ok),
		.fault_raw(fault_raw), .latchoff_enable(latchoff_enable), .clock_out_enable(clock_out_enable),
		.dim_type_bam(dim_type_bam), .ch1_analog_level(ch1_analog_level), .ch2_analog_level(ch2_analog_level),
		.dim_on(dim_on), .bus_mode(bus_mode));

	// ==================================================
	// Clocks and watchdog
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		sw_clock = 1'b0;
		#3.3;
		forever #7.5 sw_clock = ~sw_clock;
	end
	initial begin
		repeat (100000) @(posedge clock);
		fails++;
		results();
	end

	// ==================================================
	// Access tasks
	function automatic logic [7:0] adr(input logic rd_bit);
		return {ADDR_FIXED, pin_hi == PIN_HIGH, pin_hi != PIN_GND, pin_lo == PIN_HIGH, pin_lo != PIN_GND, rd_bit};
	endfunction

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] sub, input logic [7:0] d, input logic fin);
		master.start();
		master.wbyte(adr(1'b0), ack);
		`CHK("write addr ack", 1'b1, ack);
		master.wbyte(sub, ack);
		`CHK("sub ack", 1'b1, ack);
		master.wbyte(d, ack);
		`CHK("data ack", 1'b1, ack);
		if (fin) begin
			master.stop();
		end
	endtask

	task automatic rd_now(input logic [7:0] e);
		master.start();
		master.wbyte(adr(1'b1), ack);
		`CHK("read addr ack", 1'b1, ack);
		master.rbyte(1'b0, rd);
		`CHK("read data", e, rd);
	endtask

	task automatic rd_chk(input logic [7:0] sub, input logic [7:0] e);
		master.start();
		master.wbyte(adr(1'b0), ack);
		master.wbyte(sub, ack);
		`CHK("pointer ack", 1'b1, ack);
		rd_now(e);
	endtask

	task automatic results();
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==================================================
	// Scenarios
	initial begin
		rstn = 1'b0;
		pin_hi = PIN_FLOAT;
		pin_lo = PIN_FLOAT;
		supply_ok = 1'b1;
		fault_raw = 8'h00;
		repeat (5) @(posedge clock);
		#1;
		rstn = 1'b1;
		wait_cyc(8);
		for (int s = 0; s < 13; s++) begin
			rd_chk(8'(s), DEF_VAL[s]);
		end
		`CHK("analog1 out", 8'hff, ch1_analog_level);
		`CHK("dim out", 2'b00, dim_on);
		`CHK("latchoff reset", 1'b0, latchoff_enable);
		`CHK("dim type reset", 2'b00, dim_type_bam);
		for (int s = 2; s < 9; s++) begin
			wr(8'(s), 8'(s), 1'b1);
			rd_chk(8'(s), 8'(s));
		end
		`CHK("analog2 out", 8'h07, ch2_analog_level);
		wr(SUB_CH1_ANALOG, 8'h55, 1'b0);
		rd_chk(SUB_CH1_ANALOG, 8'h55);
		rd_now(8'h55);
		master.start();
		master.wbyte(adr(1'b1), ack);
		`CHK("burst addr ack", 1'b1, ack);
		master.rbyte(1'b1, rd);
		`CHK("burst first", 8'h55, rd);
		master.rbyte(1'b0, rd);
		`CHK("burst again", 8'h55, rd);
		`CHK("analog1 held", 8'h06, ch1_analog_level);
		master.start();
		master.wbyte(8'h70, ack);
		`CHK("foreign ack", 1'b0, ack);
		master.stop();
		wait_cyc(10);
		`CHK("analog1 out", 8'h55, ch1_analog_level);
		wr(SUB_CONFIG, 8'hf2, 1'b1);
		rd_chk(SUB_CONFIG, 8'hc2);
		wait_cyc(20);
		`CHK("latchoff", 1'b1, latchoff_enable);
		`CHK("clock out", 1'b1, clock_out_enable);
		`CHK("dim type", 2'b01, dim_type_bam);
		`CHK("dim forced on", 2'b11, dim_on);
		fault_raw = 8'ha5;
		wr(SUB_REPORT, 8'h0f, 1'b1);
		rd_chk(SUB_FAULT, 8'h05);
		wr(SUB_FAULT, 8'hff, 1'b1);
		wr(8'h0d, 8'h11, 1'b1);
		rd_chk(SUB_FAULT, 8'h05);
		rd_chk(SUB_CONFIG, 8'hc2);
		master.start();
		master.wbyte(8'h18, ack);
		`CHK("broadcast ack", 1'b1, ack);
		master.wbyte(SUB_CH1_ANALOG, ack);
		master.wbyte(8'h00, ack);
		master.stop();
		rd_chk(SUB_CH1_ANALOG, 8'h55);
		master.start();
		master.wbyte(8'h19, ack);
		`CHK("broadcast read ack", 1'b0, ack);
		master.stop();
		for (int h = 2; h >= 0; h--) begin
			for (int l = 2; l >= 0; l--) begin
				pin_hi = 2'(h);
				pin_lo = 2'(l);
				wait_cyc(10);
				master.start();
				master.wbyte(adr(1'b0), ack);
				`CHK("own ack", 1'b1, ack);
				master.stop();
				master.start();
				master.wbyte(adr(1'b0) ^ 8'h02, ack);
				`CHK("other ack", 1'b0, ack);
				master.stop();
				`CHK("bus mode", (h != 0 || l != 0), bus_mode);
			end
		end
		wr(SUB_CH1_LO, 8'h00, 1'b1);
		wr(SUB_CH2_LO, 8'h00, 1'b1);
		wr(SUB_CONFIG, 8'h0c, 1'b1);
		wait_cyc(10);
		`CHK("non-bus dim", 2'b11, dim_on);
		supply_ok = 1'b0;
		wait_cyc(10);
		supply_ok = 1'b1;
		pin_hi = PIN_FLOAT;
		pin_lo = PIN_FLOAT;
		wait_cyc(10);
		`CHK("analog1 reset", 8'hff, ch1_analog_level);
		rd_chk(SUB_CONFIG, RST_CONFIG);
		rd_chk(SUB_CH2_ANALOG, RST_ANALOG);
		`CHK("dim after supply", 2'b00, dim_on);
		results();
	end
endmodule

// [bench/ledi_master.sv]
// Bus master model that drives the two-wire port of the LED driver.
`timescale 1ns/1ps
module ledi_master
	import ledi_pkg::*;
(
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// ==================================================
	// Bus timing
	// One quarter of a bit period, in system clock cycles; keeps both clock phases at ten cycles.
	localparam int QUARTER = 5;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic step();
		repeat (QUARTER) @(posedge clock);
		#1;
	endtask

	// ==================================================
	// Conditions and bits
	// A start from idle or a repeated start after a byte.
	task automatic start();
		sda_pull = 1'b0;
		step();
		scl = 1'b1;
		step();
		sda_pull = 1'b1;
		step();
		scl = 1'b0;
		step();
	endtask

	task automatic stop();
		sda_pull = 1'b1;
		step();
		scl = 1'b1;
		step();
		sda_pull = 1'b0;
		step();
	endtask

	// Data changes only while the clock is low and is sampled in the middle of the high phase.
	task automatic bit_io(input logic b, output logic got);
		sda_pull = ~b;
		step();
		scl = 1'b1;
		step();
		got = sda;
		step();
		scl = 1'b0;
		step();
	endtask

	// ==================================================
	// Bytes
	// Eight bits sent most significant first, then the acknowledge clock with the line released.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic line;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], line);
		end
		bit_io(1'b1, line);
		ack = ~line;
	endtask

	// Eight bits are taken from the target, then the master acknowledges or not.
	task automatic rbyte(input logic ack_it, output logic [7:0] d);
		logic line;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack_it, line);
	endtask
endmodule

// [common/ledi_pkg.sv]
// Shared constants and types for the LED driver bus register port.
package ledi_pkg;

	// ==================================================
	// Addressing
	localparam logic [2:0] ADDR_FIXED = 3'h6;
	localparam logic [6:0] GLOBAL_ADDR = 7'h0c;
	localparam logic [1:0] PIN_GND = 2'h0;
	localparam logic [1:0] PIN_FLOAT = 2'h1;
	localparam logic [1:0] PIN_HIGH = 2'h2;

	// ==================================================
	// Sub-addresses
	localparam logic [7:0] SUB_CONFIG = 8'h01;
	localparam logic [7:0] SUB_CH1_HI = 8'h02;
	localparam logic [7:0] SUB_CH1_LO = 8'h03;
	localparam logic [7:0] SUB_CH2_HI = 8'h04;
	localparam logic [7:0] SUB_CH2_LO = 8'h05;
	localparam logic [7:0] SUB_CH1_ANALOG = 8'h06;
	localparam logic [7:0] SUB_CH2_ANALOG = 8'h07;
	localparam logic [7:0] SUB_REPORT = 8'h08;
	localparam logic [7:0] SUB_FAULT = 8'h09;
	localparam logic [7:0] SUB_ID0 = 8'h0a;
	localparam logic [7:0] SUB_ID1 = 8'h0b;
	localparam logic [7:0] SUB_ID2 = 8'h0c;

	// ==================================================
	// Reset values and the configuration write mask
	localparam logic [7:0] RST_CONFIG = 8'h0c;
	localparam logic [7:0] RST_PULSE = 8'h00;
	localparam logic [7:0] RST_ANALOG = 8'hff;
	localparam logic [7:0] RST_REPORT = 8'hff;
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [7:0] CONFIG_USED_MASK = 8'hcf;

	// ==================================================
	// Field positions
	localparam int CFG_LATCHOFF = 7;
	localparam int CFG_CLKOUT = 6;
	localparam int CFG_CH1_EN = 3;
	localparam int CFG_CH2_EN = 2;
	localparam int CFG_CH1_BAM = 1;
	localparam int CFG_CH2_BAM = 0;
	localparam int PULSE_SCALE_LSB = 5;

	// ==================================================
	// Dimming settings passed to the switching-clock domain
	typedef struct packed {
		logic enable;
		logic [2:0] scale;
		logic [12:0] on_time;
	} ledi_chan_t;

endpackage

// [core/ledi_dimmer.sv]
// Dimming counters running on the switching clock.
`timescale 1ns/1ps
module ledi_dimmer
	import ledi_pkg::*;
(
	input wire logic sw_clock,
	input wire logic rstn,
	input wire logic cfg_toggle,
	input wire ledi_chan_t [1:0] cfg_word,
	input wire logic sync_toggle,
	output logic [1:0] dim_on
);

	// ==================================================
	// Crossing of settings and the broadcast event
	logic cfg_m, cfg_s, cfg_d;
	logic bc_m, bc_s, bc_d;
	ledi_chan_t [1:0] cfg_local;

	always_ff @(posedge sw_clock or negedge rstn) begin
		if (!rstn) begin
			cfg_m <= 1'b0;
			cfg_s <= 1'b0;
			cfg_d <= 1'b0;
			bc_m <= 1'b0;
			bc_s <= 1'b0;
			bc_d <= 1'b0;
		end else begin
			cfg_m <= cfg_toggle;
			cfg_s <= cfg_m;
			cfg_d <= cfg_s;
			bc_m <= sync_toggle;
			bc_s <= bc_m;
			bc_d <= bc_s;
		end
	end

	// The word is stable long before its toggle arrives here.
	always_ff @(posedge sw_clock or negedge rstn) begin
		if (!rstn) begin
			cfg_local <= '0;
		end else if (cfg_s != cfg_d) begin
			cfg_local <= cfg_word;
		end
	end

	function automatic logic [12:0] period_mask(input logic [2:0] scale);
		period_mask = 13'h1fff >> (3'h7 - scale);
	endfunction

	// ==================================================
	// Per-channel counters
	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			logic [12:0] count;
			logic [12:0] mask;
			assign mask = period_mask(cfg_local[c].scale);
			always_ff @(posedge sw_clock or negedge rstn) begin
				if (!rstn) begin
					count <= 13'h0000;
				end else if (bc_s != bc_d) begin
					count <= 13'h0000;
				end else begin
					count <= (count + 13'h0001) & mask;
				end
			end
			always_ff @(posedge sw_clock or negedge rstn) begin
				if (!rstn) begin
					dim_on[c] <= 1'b1;
				end else begin
					dim_on[c] <= !cfg_local[c].enable || (count < (cfg_local[c].on_time & mask));
				end
			end
		end
	endgenerate

endmodule

// [core/ledi_port.sv]
// Bus target port with command registers of the dual LED driver.
`timescale 1ns/1ps
module ledi_port
	import ledi_pkg::*;
#(
	parameter logic [7:0] ID_VALUE0 = 8'h11, // Arbitrary value.
	parameter logic [7:0] ID_VALUE1 = 8'h22, // Arbitrary value.
	parameter logic [7:0] ID_VALUE2 = 8'h33 // Arbitrary value.
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic sw_clock,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] addr_select_high_pin,
	input wire logic [1:0] addr_select_low_pin,
	input wire logic internal_supply_ok,
	input wire logic [7:0] fault_raw,
	output logic latchoff_enable,
	output logic clock_out_enable,
	output logic [1:0] dim_type_bam,
	output logic [7:0] ch1_analog_level,
	output logic [7:0] ch2_analog_level,
	output logic [1:0] dim_on,
	output logic bus_mode
);

	typedef enum {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK, S_DATA, S_DATA_ACK, S_READ, S_READ_ACK
	} ledi_state_t;

	// ==================================================
	// Pin synchronisers
	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;
	logic supply_m, supply_s;
	logic [1:0] hi_m, hi_s, lo_m, lo_s;
	logic [7:0] fault_m, fault_s;
	logic non_bus;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			supply_m <= 1'b0;
			supply_s <= 1'b0;
			hi_m <= PIN_GND;
			hi_s <= PIN_GND;
			lo_m <= PIN_GND;
			lo_s <= PIN_GND;
			fault_m <= 8'h00;
			fault_s <= 8'h00;
			non_bus <= 1'b1;
		end else begin
			scl_m <= scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
			supply_m <= internal_supply_ok;
			supply_s <= supply_m;
			hi_m <= addr_select_high_pin;
			hi_s <= hi_m;
			lo_m <= addr_select_low_pin;
			lo_s <= lo_m;
			fault_m <= fault_raw;
			fault_s <= fault_m;
			non_bus <= (hi_s == PIN_GND) && (lo_s == PIN_GND);
		end
	end

	// ==================================================
	// Bus events and address decode
	logic start_det, stop_det, scl_rise, scl_fall, quiet;
	logic [6:0] own_addr;
	logic own_hit, global_wr, addr_hit;

	function automatic logic [1:0] pin_bits(input logic [1:0] code);
		pin_bits = {code == PIN_HIGH, code != PIN_GND};
	endfunction

	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det = scl_s && scl_d && !sda_d && sda_s;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign quiet = supply_s && !start_det && !stop_det;
	assign own_addr = {ADDR_FIXED, pin_bits(hi_s), pin_bits(lo_s)};

	// ==================================================
	// Protocol engine
	ledi_state_t st;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic got8, is_read, is_bcast, master_ack;
	logic [7:0] pointer, hold_addr, hold_data;
	logic pending, sync_toggle;
	logic [7:0] cmd [1:8];
	logic [7:0] fault_flags;
	logic [7:0] read_word;

	assign own_hit = shift[7:1] == own_addr;
	assign global_wr = shift == {GLOBAL_ADDR, 1'b0};
	assign addr_hit = own_hit || global_wr;
	assign sda_out = 1'b0;

	function automatic logic [7:0] reg_value(input logic [7:0] sub, input logic [7:0] fault);
		case (sub)
			SUB_CONFIG, SUB_CH1_HI, SUB_CH1_LO, SUB_CH2_HI, SUB_CH2_LO,
			SUB_CH1_ANALOG, SUB_CH2_ANALOG, SUB_REPORT: reg_value = cmd[sub[3:0]];
			SUB_FAULT: reg_value = fault;
			SUB_ID0: reg_value = ID_VALUE0;
			SUB_ID1: reg_value = ID_VALUE1;
			SUB_ID2: reg_value = ID_VALUE2;
			default: reg_value = 8'h00;
		endcase
	endfunction

	// A read taken before STOP sees the pending byte, not the committed one.
	assign read_word = (pending && pointer == hold_addr) ? hold_data : reg_value(pointer, fault_flags);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= S_IDLE;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			got8 <= 1'b0;
			is_read <= 1'b0;
			is_bcast <= 1'b0;
			master_ack <= 1'b0;
			pointer <= 8'h00;
			hold_addr <= 8'h00;
			hold_data <= 8'h00;
			pending <= 1'b0;
			sync_toggle <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!supply_s) begin
			st <= S_IDLE;
			bit_cnt <= 3'h0;
			got8 <= 1'b0;
			pointer <= 8'h00;
			pending <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			st <= S_IDLE;
			sda_oe <= 1'b0;
			pending <= 1'b0;
		end else if (start_det) begin
			st <= S_ADDR;
			bit_cnt <= 3'h0;
			got8 <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			case (st)
				S_ADDR, S_SUB, S_DATA: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 3'h1;
						got8 <= bit_cnt == 3'h7;
					end else if (scl_fall && got8) begin
						got8 <= 1'b0;
						if (st == S_ADDR) begin
							if (addr_hit) begin
								st <= S_ADDR_ACK;
								sda_oe <= 1'b1;
								is_read <= shift[0];
								is_bcast <= global_wr;
								if (global_wr) begin
									sync_toggle <= !sync_toggle;
								end
							end else begin
								st <= S_IDLE;
							end
						end else if (st == S_SUB) begin
							pointer <= shift;
							st <= S_SUB_ACK;
							sda_oe <= 1'b1;
						end else begin
							hold_data <= shift;
							hold_addr <= pointer;
							pending <= 1'b1;
							st <= S_DATA_ACK;
							sda_oe <= 1'b1;
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (is_bcast) begin
							st <= S_IDLE;
							sda_oe <= 1'b0;
						end else if (is_read) begin
							st <= S_READ;
							shift <= read_word;
							sda_oe <= !read_word[7];
						end else begin
							st <= S_SUB;
							sda_oe <= 1'b0;
						end
					end
				end
				S_SUB_ACK, S_DATA_ACK: begin
					if (scl_fall) begin
						st <= S_DATA;
						sda_oe <= 1'b0;
						bit_cnt <= 3'h0;
					end
				end
				S_READ: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							st <= S_READ_ACK;
							sda_oe <= 1'b0;
							bit_cnt <= 3'h0;
						end else begin
							shift <= {shift[6:0], 1'b0};
							sda_oe <= !shift[6];
							bit_cnt <= bit_cnt + 3'h1;
						end
					end
				end
				S_READ_ACK: begin
					if (scl_rise) begin
						master_ack <= !sda_s;
					end else if (scl_fall) begin
						if (master_ack) begin
							st <= S_READ;
							shift <= read_word;
							sda_oe <= !read_word[7];
						end else begin
							st <= S_IDLE;
						end
					end
				end
				default: begin
					st <= S_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ==================================================
	// Command registers
	function automatic logic [7:0] reset_value(input int idx);
		case (idx)
			1: reset_value = RST_CONFIG;
			6, 7: reset_value = RST_ANALOG;
			8: reset_value = RST_REPORT;
			default: reset_value = RST_PULSE;
		endcase
	endfunction

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 1; i <= 8; i++) begin
				cmd[i] <= reset_value(i);
			end
		end else if (!supply_s) begin
			for (int i = 1; i <= 8; i++) begin
				cmd[i] <= reset_value(i);
			end
		end else if (stop_det && pending && hold_addr >= SUB_CONFIG && hold_addr <= SUB_REPORT) begin
			cmd[hold_addr[3:0]] <= (hold_addr == SUB_CONFIG) ? (hold_data & CONFIG_USED_MASK) : hold_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_flags <= RST_FAULT;
		end else if (!supply_s) begin
			fault_flags <= RST_FAULT;
		end else begin
			fault_flags <= fault_s & cmd[8];
		end
	end

	assign latchoff_enable = cmd[1][CFG_LATCHOFF];
	assign clock_out_enable = cmd[1][CFG_CLKOUT];
	assign dim_type_bam = {cmd[1][CFG_CH2_BAM], cmd[1][CFG_CH1_BAM]};
	assign ch1_analog_level = cmd[6];
	assign ch2_analog_level = cmd[7];
	assign bus_mode = !non_bus;

	// ==================================================
	// Settings handed to the dimming counters
	ledi_chan_t [1:0] cfg_now, cfg_hold;
	logic cfg_toggle;

	assign cfg_now[0] = '{enable: cmd[1][CFG_CH1_EN] && !non_bus, scale: cmd[2][7:PULSE_SCALE_LSB],
		on_time: {cmd[2][4:0], cmd[3]}};
	assign cfg_now[1] = '{enable: cmd[1][CFG_CH2_EN] && !non_bus, scale: cmd[4][7:PULSE_SCALE_LSB],
		on_time: {cmd[4][4:0], cmd[5]}};

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_hold <= '0;
			cfg_toggle <= 1'b0;
		end else if (cfg_now != cfg_hold) begin
			cfg_hold <= cfg_now;
			cfg_toggle <= !cfg_toggle;
		end
	end

	ledi_dimmer u_dimmer (
		.sw_clock(sw_clock),
		.rstn(rstn),
		.cfg_toggle(cfg_toggle),
		.cfg_word(cfg_hold),
		.sync_toggle(sync_toggle),
		.dim_on(dim_on)
	);

	// ==================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_own_address: assert property (hi_s == PIN_HIGH && lo_s == PIN_FLOAT |-> own_addr == 7'h6d)
		else $error("own address decode wrong");
	a_addr_nack: assert property (st == S_ADDR && scl_fall && got8 && !addr_hit && quiet
		|=> st == S_IDLE && !sda_oe) else $error("foreign address acknowledged");
	a_ack_drive: assert property (st == S_DATA_ACK || st == S_SUB_ACK |-> sda_oe)
		else $error("acknowledge not driven low");
	a_latch_data: assert property (st == S_DATA && scl_fall && got8 && quiet
		|=> pending && hold_data == $past(shift) && st == S_DATA_ACK) else $error("data not latched");
	a_commit_stop: assert property ($changed(ch1_analog_level) |-> $past(stop_det) || !$past(supply_s))
		else $error("register changed without stop");
	a_pointer_hold: assert property ($changed(pointer) |-> $past(st) == S_SUB || !$past(supply_s))
		else $error("pointer changed without sub-address");
	a_read_latch: assert property (st == S_ADDR_ACK && scl_fall && is_read && !is_bcast && pending
		&& pointer == hold_addr && quiet |=> shift == $past(hold_data)) else $error("read ignores latch");
	a_bcast_sync: assert property (st == S_ADDR && scl_fall && got8 && global_wr && quiet
		|=> sync_toggle != $past(sync_toggle)) else $error("broadcast did not resync");
	a_dir_bit: assert property (st == S_ADDR_ACK && scl_fall && !is_bcast && quiet
		|=> st == ($past(is_read) ? S_READ : S_SUB)) else $error("direction bit misread");
	a_fault_gate: assert property (1'b1 |=> fault_flags ==
		($past(supply_s) ? ($past(fault_s) & $past(cmd[8])) : RST_FAULT)) else $error("fault flags wrong");
	a_supply_reset: assert property (!supply_s |=> ch1_analog_level == RST_ANALOG && pointer == 8'h00)
		else $error("supply loss did not reset");
	a_nonbus_dim: assert property ($past(non_bus) |-> !cfg_hold[0].enable && !cfg_hold[1].enable)
		else $error("dimming active in non-bus mode");

endmodule
